/* cprm_pkg.sv */
package cprm_pkg;
   // ==========================================================
   // Clock and timing
   // ==========================================================
   localparam int CLK_PERIOD_PS = 5000; // 200 MHz mclk
   localparam int OSC_SETTLE_NS = 1000; // Main oscillator start-up time
   localparam int OSC_SETTLE_CYC = (OSC_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int POR_NS = 2000; // Chip power-on reset width
   localparam int POR_CYC = (POR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int FRST_NS = 500; // Functional reset width
   localparam int FRST_CYC = (FRST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int WD_DIV = 14; // Watchdog clock = reference / 14
   localparam int LF_PERIPH_W = 4; // Peripherals that may run from 32 kHz

   // ==========================================================
   // Register map (byte offsets)
   // ==========================================================
   localparam logic [7:0] OFS_DSP_CLK_CTL = 8'h00;
   localparam logic [7:0] OFS_DSP_IDLE1 = 8'h04;
   localparam logic [7:0] OFS_DSP_IDLE2 = 8'h08;
   localparam logic [7:0] OFS_DSP_RST2 = 8'h14;
   localparam logic [7:0] OFS_DSP_STATUS = 8'h18;
   localparam logic [7:0] OFS_HOST_PWR = 8'h20;

   // ==========================================================
   // Field positions and reset values
   // ==========================================================
   localparam int IDLE1_MASK_HOST = 0; // Wake mask, host interrupt
   localparam int IDLE1_MASK_DSP = 1; // Wake mask, DSP interrupt
   localparam int IDLE2_WD_EN = 0; // Watchdog clock enable
   localparam int RST2_PER_EN = 0; // Peripheral bus out of reset
   localparam int RST2_SW_RST = 1; // Software reset request
   localparam int SYS_WD_HOST = 0; // Sticky status bits
   localparam int SYS_WD_DSP = 1;
   localparam int SYS_EXT_RST = 2;
   localparam int SYS_POR = 3;
   localparam int SYS_STATE_LO = 4; // Power state, 3 bits
   localparam int PWR_REQ_LO = 0; // Power request, 2 bits
   localparam int PWR_PLL_LO = 2; // PLL mode, 2 bits
   localparam int PWR_SEL_LO = 4; // Clock select, 3 bits
   localparam logic [15:0] RST_DSP_CLK_CTL = 16'h0000;
   localparam logic [15:0] RST_DSP_IDLE1 = 16'h0000;
   localparam logic [15:0] RST_DSP_IDLE2 = 16'h0001;
   localparam logic [15:0] RST_DSP_RST2 = 16'h0000;

   // ==========================================================
   // Encodings
   // ==========================================================
   localparam logic [1:0] REQ_AWAKE = 2'h0;
   localparam logic [1:0] REQ_BIG = 2'h1;
   localparam logic [1:0] REQ_DEEP = 2'h2;
   localparam logic [1:0] PLL_IDLE = 2'h0;
   localparam logic [1:0] PLL_BYPASS = 2'h1;
   localparam logic [1:0] PLL_LOCK = 2'h2;
   localparam logic [2:0] SEL_FULL_SYNC = 3'h0;
   localparam logic [2:0] SEL_SCALABLE = 3'h2;

   typedef enum logic [2:0] {
      PS_DEEP, PS_OSC_START, PS_FEED_ON, PS_AWAKE, PS_PLL_STOP, PS_FEED_STOP, PS_BIG
   } cprm_state_e;

   // Wake sources seen while sleeping
   typedef struct packed {
      logic irq_host;
      logic irq_dsp;
      logic local_bus_wake_pin;
      logic dma_req_traffic;
      logic dma_req_per;
   } cprm_wake_s;

   // Oscillator and PLL controls
   typedef struct packed {
      logic osc_lf_en;
      logic osc_hf_en;
      logic hf_feed_en;
      logic pll_en;
      logic pll_bypass;
   } cprm_clk_s;
endpackage

/* cprm_div.sv */
`timescale 1ns/1ps
// ==========================================================
// Divide-by-N enable pulse generator
// ==========================================================
module cprm_div #(
   parameter int DIV = 14
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Pulse out, one cycle in DIV
   output logic tick
);
   logic [7:0] cnt; // Cycles since last pulse

   // Free-running count, wraps at DIV-1
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         cnt <= 8'h00;
         tick <= 1'b0;
      end else if (cnt == 8'(DIV - 1)) begin
         cnt <= 8'h00;
         tick <= 1'b1;
      end else begin
         cnt <= cnt + 8'h01;
         tick <= 1'b0;
      end
   end
endmodule

/* cprm_top.sv */
`timescale 1ns/1ps
// Operation
// - awake: both oscillators, feed on, PLL optional
// - big sleep: oscillators on, no feed, PLLs off
// - deep sleep: only low-frequency oscillator runs
// - clock or wake request starts oscillator, no interrupt
// - failed battery drives shutdown output
// - generate functional reset and chip power-on reset
// - switch chosen peripherals to low-frequency clock
// - global, software and peripheral bus resets
// - watch reset sources, record sticky status
// - fully synchronous after power-up, scalable selectable
// - PLL modes locked, bypass and idle
// - watchdog clock is reference divided by fourteen
// - DMA clock only during transfer
// - wake on interrupts, local bus pin, DMA
// - only unmasked interrupts wake
// - 16-bit control registers, both processors access
// - clock select zero is default full sync
module cprm_top
   import cprm_pkg::*;
#(
   parameter int OSC_SETTLE = cprm_pkg::OSC_SETTLE_CYC,
   parameter int POR_LEN = cprm_pkg::POR_CYC,
   parameter int FRST_LEN = cprm_pkg::FRST_CYC
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Register port
   input wire logic reg_req,
   input wire logic reg_wr,
   input wire logic reg_from_dsp,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   output logic reg_ack,
   // Wake and clock requests
   input wire cprm_pkg::cprm_wake_s wake_in,
   input wire logic ext_clk_req,
   input wire logic periph_wake_req,
   input wire logic dma_clk_req,
   input wire logic dma_xfer_active,
   // Reset sources
   input wire logic wd_timeout_host,
   input wire logic wd_timeout_dsp,
   input wire logic ext_reset_req,
   input wire logic battery_failed,
   // Clock controls
   output cprm_pkg::cprm_clk_s clk_out,
   output logic scheme_scalable,
   output logic [cprm_pkg::LF_PERIPH_W-1:0] periph_lf_sel,
   output logic wd_tick_host,
   output logic wd_tick_dsp,
   output logic dma_clk_en,
   // Reset outputs
   output logic chip_por_n,
   output logic func_reset_n,
   output logic global_reset_n,
   output logic periph_reset_n,
   output logic shutdown_out
);
   import cprm_pkg::*;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   // ==========================================================
   // Registers
   // ==========================================================
   logic [15:0] dsp_clock_control; // Low-frequency select in low bits
   logic [15:0] dsp_idle_entry_one; // Interrupt wake masks
   logic [15:0] dsp_idle_entry_two; // Watchdog clock enable
   logic [15:0] dsp_reset_control_two; // Peripheral and software reset
   logic [3:0] sys_flags; // Sticky reset status
   logic [1:0] pwr_req; // Requested power state
   logic [1:0] pll_mode; // PLL operating mode
   logic [2:0] clock_select; // Clocking scheme
   cprm_state_e state_q, next_state; // Power state machine
   logic [8:0] settle_cnt; // Oscillator start-up count
   logic [8:0] por_cnt; // Power-on reset count
   logic por_done; // Power-on reset finished
   logic [7:0] frst_cnt; // Functional reset count
   logic wake_ev; // Qualified wake event
   logic hf_req; // External high-frequency request
   logic rst_ev; // Any functional reset source
   logic wr_en; // Register write this cycle
   logic wd_base; // Reference divided by fourteen

   assign wr_en = reg_req && reg_wr;
   assign hf_req = ext_clk_req || periph_wake_req;
   assign rst_ev = wd_timeout_host || wd_timeout_dsp || ext_reset_req;
   // Masked interrupts never wake; DMA and bus pin always do
   assign wake_ev = (wake_in.irq_host && !dsp_idle_entry_one[IDLE1_MASK_HOST])
      || (wake_in.irq_dsp && !dsp_idle_entry_one[IDLE1_MASK_DSP])
      || wake_in.local_bus_wake_pin || wake_in.dma_req_traffic || wake_in.dma_req_per;

   // ==========================================================
   // Register bus
   // ==========================================================
   // Answer one cycle after the request, unmapped reads give zero
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         reg_ack <= 1'b0;
         reg_rdata <= 16'h0000;
      end else begin
         reg_ack <= reg_req;
         reg_rdata <= 16'h0000;
         if (reg_req && !reg_wr) begin
            case (reg_addr)
               OFS_DSP_CLK_CTL: reg_rdata <= dsp_clock_control;
               OFS_DSP_IDLE1: reg_rdata <= dsp_idle_entry_one;
               OFS_DSP_IDLE2: reg_rdata <= dsp_idle_entry_two;
               OFS_DSP_RST2: reg_rdata <= dsp_reset_control_two;
               OFS_DSP_STATUS: reg_rdata <= {9'h000, state_q, sys_flags};
               OFS_HOST_PWR: reg_rdata <= {9'h000, clock_select, pll_mode, pwr_req};
               default: reg_rdata <= 16'h0000;
            endcase
         end
      end
   end

   // Plain control registers, either processor may write
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         dsp_clock_control <= RST_DSP_CLK_CTL;
         dsp_idle_entry_one <= RST_DSP_IDLE1;
         dsp_idle_entry_two <= RST_DSP_IDLE2;
      end else if (wr_en) begin
         if (reg_addr == OFS_DSP_CLK_CTL) begin
            dsp_clock_control <= reg_wdata;
         end
         if (reg_addr == OFS_DSP_IDLE1) begin
            dsp_idle_entry_one <= reg_wdata;
         end
         if (reg_addr == OFS_DSP_IDLE2) begin
            dsp_idle_entry_two <= reg_wdata;
         end
      end
   end

   // Reset control; the software request bit clears itself
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         dsp_reset_control_two <= RST_DSP_RST2;
      end else if (wr_en && reg_addr == OFS_DSP_RST2) begin
         dsp_reset_control_two <= reg_wdata;
      end else begin
         dsp_reset_control_two[RST2_SW_RST] <= 1'b0;
      end
   end

   // Sticky status, write one to clear; a new event beats the clear
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sys_flags <= 4'h8; // Power-on flag up after cold start
      end else begin
         if (wr_en && reg_addr == OFS_DSP_STATUS) begin
            sys_flags <= sys_flags & ~reg_wdata[3:0];
         end
         if (wd_timeout_host) begin
            sys_flags[SYS_WD_HOST] <= 1'b1;
         end
         if (wd_timeout_dsp) begin
            sys_flags[SYS_WD_DSP] <= 1'b1;
         end
         if (ext_reset_req) begin
            sys_flags[SYS_EXT_RST] <= 1'b1;
         end
      end
   end

   // Host-only power register; DSP writes are dropped since it owns only its peripherals
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pwr_req <= REQ_AWAKE;
         pll_mode <= PLL_LOCK;
         clock_select <= SEL_FULL_SYNC;
      end else begin
         if (wr_en && reg_addr == OFS_HOST_PWR && !reg_from_dsp) begin
            if (reg_wdata[PWR_REQ_LO+1 -: 2] != 2'h3) begin
               pwr_req <= reg_wdata[PWR_REQ_LO+1 -: 2];
            end
            if (reg_wdata[PWR_PLL_LO+1 -: 2] != 2'h3) begin
               pll_mode <= reg_wdata[PWR_PLL_LO+1 -: 2];
            end
            // Reserved schemes are ignored, not stored
            if (reg_wdata[PWR_SEL_LO+2 -: 3] == SEL_FULL_SYNC
                || reg_wdata[PWR_SEL_LO+2 -: 3] == SEL_SCALABLE) begin
               clock_select <= reg_wdata[PWR_SEL_LO+2 -: 3];
            end
         end
         // A wake event while asleep turns the request back to awake
         if (wake_ev && (state_q == PS_DEEP || state_q == PS_BIG) && por_done) begin
            pwr_req <= REQ_AWAKE;
         end
      end
   end

   // ==========================================================
   // Power state machine
   // ==========================================================
   // Down: PLL off, then feed off, then oscillator off; up in reverse
   always_comb begin
      next_state = state_q;
      case (state_q)
         PS_DEEP: begin
            if (por_done && pwr_req != REQ_DEEP) begin
               next_state = PS_OSC_START;
            end
         end
         PS_OSC_START: begin
            if (settle_cnt == 9'(OSC_SETTLE - 1)) begin
               next_state = (pwr_req == REQ_AWAKE) ? PS_FEED_ON : PS_BIG;
            end
         end
         PS_FEED_ON: next_state = PS_AWAKE;
         PS_AWAKE: begin
            if (pwr_req != REQ_AWAKE) begin
               next_state = PS_PLL_STOP;
            end
         end
         PS_PLL_STOP: next_state = PS_FEED_STOP;
         PS_FEED_STOP: next_state = (pwr_req == REQ_DEEP) ? PS_DEEP : PS_BIG;
         PS_BIG: begin
            if (pwr_req == REQ_AWAKE) begin
               next_state = PS_FEED_ON;
            end else if (pwr_req == REQ_DEEP) begin
               next_state = PS_DEEP;
            end
         end
         default: next_state = PS_DEEP;
      endcase
   end

   // State register, deep sleep held through power-on reset
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_q <= PS_DEEP;
      end else begin
         state_q <= next_state;
      end
   end

   // Oscillator start-up timer
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         settle_cnt <= 9'h000;
      end else if (state_q == PS_OSC_START) begin
         settle_cnt <= settle_cnt + 9'h001;
      end else begin
         settle_cnt <= 9'h000;
      end
   end

   // Oscillator, feed and PLL controls follow the next state
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         clk_out <= '0;
      end else begin
         clk_out.osc_lf_en <= 1'b1;
         // Requests keep the main oscillator up in any state, with no interrupt raised
         clk_out.osc_hf_en <= (next_state != PS_DEEP) || hf_req;
         clk_out.hf_feed_en <= next_state == PS_FEED_ON || next_state == PS_AWAKE
            || next_state == PS_PLL_STOP;
         clk_out.pll_en <= next_state == PS_AWAKE && pll_mode != PLL_IDLE;
         clk_out.pll_bypass <= pll_mode == PLL_BYPASS;
      end
   end

   // ==========================================================
   // Clock distribution
   // ==========================================================
   cprm_div #(
      .DIV(WD_DIV)
   ) u_wd_div (
      .mclk(mclk),
      .resetn(resetn),
      .tick(wd_base)
   );

   // Watchdog ticks, scheme select, peripheral clock switch, DMA gate
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         wd_tick_host <= 1'b0;
         wd_tick_dsp <= 1'b0;
         scheme_scalable <= 1'b0;
         periph_lf_sel <= '0;
         dma_clk_en <= 1'b0;
      end else begin
         wd_tick_host <= wd_base;
         wd_tick_dsp <= wd_base && dsp_idle_entry_two[IDLE2_WD_EN];
         scheme_scalable <= clock_select == SEL_SCALABLE;
         periph_lf_sel <= dsp_clock_control[LF_PERIPH_W-1:0];
         dma_clk_en <= dma_clk_req && dma_xfer_active;
      end
   end

   // ==========================================================
   // Resets
   // ==========================================================
   // Power-on reset held for a fixed time after release
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         por_cnt <= 9'h000;
         por_done <= 1'b0;
      end else if (!por_done) begin
         por_cnt <= por_cnt + 9'h001;
         por_done <= por_cnt == 9'(POR_LEN - 1);
      end
   end

   // Functional reset stretched from watchdog or external sources
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         frst_cnt <= 8'h00;
      end else if (rst_ev) begin
         frst_cnt <= 8'(FRST_LEN);
      end else if (frst_cnt != 8'h00) begin
         frst_cnt <= frst_cnt - 8'h01;
      end
   end

   // Reset outputs and battery shutdown
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         chip_por_n <= 1'b0;
         func_reset_n <= 1'b0;
         global_reset_n <= 1'b0;
         periph_reset_n <= 1'b0;
         shutdown_out <= 1'b0;
      end else begin
         chip_por_n <= por_done;
         func_reset_n <= por_done && frst_cnt == 8'h00 && !rst_ev;
         global_reset_n <= por_done && frst_cnt == 8'h00 && !rst_ev
            && !dsp_reset_control_two[RST2_SW_RST];
         periph_reset_n <= dsp_reset_control_two[RST2_PER_EN] && por_done;
         shutdown_out <= battery_failed;
      end
   end

   // ==========================================================
   // Checks
   // ==========================================================
   a_awake_clocks_on: assert property (state_q == PS_AWAKE |-> clk_out.hf_feed_en && clk_out.osc_hf_en)
      else $error("awake without feed or oscillator");
   a_big_sleep_off: assert property (state_q == PS_BIG |-> !clk_out.hf_feed_en && !clk_out.pll_en)
      else $error("big sleep with feed or PLL");
   a_deep_osc_off: assert property (next_state == PS_DEEP && !hf_req |=> !clk_out.osc_hf_en)
      else $error("deep sleep with main oscillator on");
   a_ext_req_osc: assert property (hf_req |=> clk_out.osc_hf_en)
      else $error("clock request did not start oscillator");
   a_batt_shutdown: assert property (battery_failed |=> shutdown_out)
      else $error("battery failure without shutdown");
   a_feed_after_pll: assert property ($fell(clk_out.hf_feed_en) |-> !$past(clk_out.pll_en))
      else $error("feed removed while PLL on");
   a_pll_after_feed: assert property ($rose(clk_out.pll_en) |-> $past(clk_out.hf_feed_en))
      else $error("PLL on before feed");
   a_wd_div_rate: assert property (wd_base |=> !wd_base [*8] ##6 wd_base)
      else $error("watchdog tick not every fourteen cycles");
   a_dma_gate: assert property (!dma_xfer_active |=> !dma_clk_en)
      else $error("DMA clock outside transfer");
   a_wake_unmasked: assert property (state_q == PS_DEEP && por_done && wake_ev |=> ##1 state_q == PS_OSC_START)
      else $error("unmasked wake ignored");
   // The stretch length is a parameter, so hold the output low for as long as the count runs
   a_func_reset_len: assert property ((rst_ev || frst_cnt != 8'h00) |=> !func_reset_n)
      else $error("functional reset too short");
endmodule

/* cprm_dma_peer.sv */
`timescale 1ns/1ps
// ==========================================================
// DMA requester behind the traffic controller
// ==========================================================
module cprm_dma_peer (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Transfer command from the bench
   input wire logic start,
   input wire logic [7:0] len,
   // Requests into the manager
   output logic dma_clk_req,
   output logic dma_xfer_active
);
   logic [7:0] left; // Words still to move
   // Clock is requested one idle cycle before data moves, so gating is tested
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         dma_clk_req <= 1'b0;
         dma_xfer_active <= 1'b0;
         left <= 8'h00;
      end else if (start && !dma_clk_req) begin
         dma_clk_req <= 1'b1;
         left <= len;
      end else if (left != 8'h00) begin
         dma_xfer_active <= 1'b1;
         left <= left - 8'h01;
      end else begin
         // Drop both at once, clock must be gated again
         dma_clk_req <= 1'b0;
         dma_xfer_active <= 1'b0;
      end
   end
endmodule

/* tb_clock_power_reset_manager.sv */
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench
// ==========================================================
module tb_clock_power_reset_manager;
   import cprm_pkg::*;
   localparam int FRST = 4; // Short functional reset
   localparam int M_PLL = 1; // Monitor bit positions
   localparam int M_FEED = 2;
   localparam int M_HF = 3;
   localparam int M_FRST = 5;
   localparam int M_GRST = 6;
   localparam int M_POR = 7;
   localparam int M_TH = 8;
   localparam int M_TD = 9;
   logic mclk, resetn, reg_req, reg_wr, reg_from_dsp, reg_ack, dma_go, prev;
   logic [7:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, rd;
   cprm_wake_s wake;
   cprm_clk_s clk_out;
   logic ext_clk_req, periph_wake_req, dma_clk_req, dma_xfer_active, wd_host, wd_dsp, ext_rst, batt;
   logic scalable, wd_tick_host, wd_tick_dsp, dma_clk_en, chip_por_n, func_reset_n, global_reset_n;
   logic periph_reset_n, shutdown_out;
   logic [3:0] lf_sel;
   logic [9:0] mon; // Watched levels, polled by wait_mon
   int fails, check_count, n, t0;
   assign mon = {wd_tick_dsp, wd_tick_host, chip_por_n, global_reset_n, func_reset_n, clk_out};
   // Short counts keep the run brief
   cprm_top #(.OSC_SETTLE(4), .POR_LEN(8), .FRST_LEN(FRST)) i_dut (.mclk(mclk), .resetn(resetn),
      .reg_req(reg_req), .reg_wr(reg_wr), .reg_from_dsp(reg_from_dsp), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .wake_in(wake),
      .ext_clk_req(ext_clk_req), .periph_wake_req(periph_wake_req), .dma_clk_req(dma_clk_req),
      .dma_xfer_active(dma_xfer_active), .wd_timeout_host(wd_host), .wd_timeout_dsp(wd_dsp),
      .ext_reset_req(ext_rst), .battery_failed(batt), .clk_out(clk_out), .scheme_scalable(scalable),
      .periph_lf_sel(lf_sel), .wd_tick_host(wd_tick_host), .wd_tick_dsp(wd_tick_dsp),
      .dma_clk_en(dma_clk_en), .chip_por_n(chip_por_n), .func_reset_n(func_reset_n),
      .global_reset_n(global_reset_n), .periph_reset_n(periph_reset_n), .shutdown_out(shutdown_out));
   // Far-side DMA requester, four-word transfers
   cprm_dma_peer i_peer (.mclk(mclk), .resetn(resetn), .start(dma_go), .len(8'h04),
      .dma_clk_req(dma_clk_req), .dma_xfer_active(dma_xfer_active));
   // 200 MHz clock
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   // Compare and count
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Single exit of the run
   task automatic give_verdict();
      $display("checks=%0d fails=%0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // One access; the answer is due exactly one edge after it is driven
   task automatic acc(input logic wr, input logic dsp, input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk);
      #1;
      {reg_req, reg_wr, reg_from_dsp, reg_addr, reg_wdata} = {1'b1, wr, dsp, a, d};
      @(posedge mclk);
      #1;
      reg_req = 1'b0;
      chk({15'h0, reg_ack}, 16'h0001);
      rd = reg_rdata;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
      acc(1'b0, 1'b0, a, 16'h0000);
      chk(rd, exp);
   endtask
   task automatic wrd(input logic [7:0] a, input logic [15:0] d, input logic [15:0] exp);
      acc(1'b1, 1'b0, a, d);
      rdchk(a, exp);
   endtask
   // Bounded poll of one monitor bit; a timeout ends the run
   task automatic wait_mon(input int idx, input logic v, input int bound);
      n = 0;
      while (mon[idx] !== v && n < bound) begin
         @(posedge mclk);
         #1;
         n++;
      end
      chk({15'h0, mon[idx]}, {15'h0, v});
      if (mon[idx] !== v) give_verdict();
   endtask
   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      {resetn, reg_req, reg_wr, reg_from_dsp, reg_addr, reg_wdata, dma_go} = '0;
      {wake, ext_clk_req, periph_wake_req, wd_host, wd_dsp, ext_rst, batt} = '0;
      fails = 0;
      check_count = 0;
      repeat (12) @(posedge mclk);
      #1;
      chk({11'h0, clk_out}, 16'h0000);
      resetn = 1'b1;
      @(posedge mclk);
      #1;
      chk({11'h0, clk_out}, 16'h0010);
      chk({15'h0, chip_por_n}, 16'h0000);
      rdchk(OFS_DSP_STATUS, 16'h0008);
      wait_mon(M_POR, 1'b1, 20);
      wait_mon(M_FEED, 1'b1, 20);
      chk({15'h0, clk_out.pll_en}, 16'h0000);
      wait_mon(M_PLL, 1'b1, 3);
      chk({11'h0, clk_out}, 16'h001e);
      rdchk(OFS_HOST_PWR, 16'h0008);
      chk({15'h0, scalable}, 16'h0000);
      rdchk(OFS_DSP_IDLE2, RST_DSP_IDLE2);
      rdchk(8'h10, 16'h0000);
      wrd(OFS_DSP_CLK_CTL, 16'h000a, 16'h000a);
      chk({12'h0, lf_sel}, 16'h000a);
      acc(1'b1, 1'b1, OFS_HOST_PWR, 16'h0009);
      rdchk(OFS_HOST_PWR, 16'h0008);
      wrd(OFS_HOST_PWR, 16'h0028, 16'h0028);
      chk({15'h0, scalable}, 16'h0001);
      wrd(OFS_HOST_PWR, 16'h0018, 16'h0028);
      wrd(OFS_HOST_PWR, 16'h0008, 16'h0008);
      chk({15'h0, scalable}, 16'h0000);
      // Every PLL mode, then the reserved code which must not stick
      for (int m = 0; m < 4; m++) begin
         wrd(OFS_HOST_PWR, 16'(m << 2), (m == 3) ? 16'h0008 : 16'(m << 2));
         chk({14'h0, clk_out.pll_en, clk_out.pll_bypass}, (m == 0) ? 16'h0 : (m == 1) ? 16'h3 : 16'h2);
      end
      // Big sleep with both interrupts masked
      wrd(OFS_DSP_IDLE1, 16'h0003, 16'h0003);
      acc(1'b1, 1'b0, OFS_HOST_PWR, 16'h0009);
      wait_mon(M_PLL, 1'b0, 6);
      chk({15'h0, clk_out.hf_feed_en}, 16'h0001);
      wait_mon(M_FEED, 1'b0, 1);
      chk({11'h0, clk_out}, 16'h0018);
      wake = 5'h18;
      repeat (6) @(posedge mclk);
      #1;
      chk({11'h0, clk_out}, 16'h0018);
      wake = '0;
      acc(1'b1, 1'b0, OFS_DSP_IDLE1, 16'h0000);
      // Each wake source alone brings the chip back from big sleep
      for (int s = 0; s < 5; s++) begin
         acc(1'b1, 1'b0, OFS_HOST_PWR, 16'h0009);
         wait_mon(M_FEED, 1'b0, 8);
         wake = 5'(1 << s);
         wait_mon(M_PLL, 1'b1, 8);
         wake = '0;
      end
      // Deep sleep; oscillator requests must not wake the state machine
      acc(1'b1, 1'b0, OFS_HOST_PWR, 16'h000a);
      wait_mon(M_HF, 1'b0, 8);
      chk({11'h0, clk_out}, 16'h0010);
      periph_wake_req = 1'b1;
      wait_mon(M_HF, 1'b1, 3);
      rdchk(OFS_DSP_STATUS, 16'h0008);
      periph_wake_req = 1'b0;
      wait_mon(M_HF, 1'b0, 3);
      ext_clk_req = 1'b1;
      wait_mon(M_HF, 1'b1, 3);
      ext_clk_req = 1'b0;
      wake = 5'h01;
      wait_mon(M_PLL, 1'b1, 30);
      wake = '0;
      batt = 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      chk({15'h0, shutdown_out}, 16'h0001);
      batt = 1'b0;
      // Reset sources, one at a time, each leaving a sticky flag
      acc(1'b1, 1'b0, OFS_DSP_STATUS, 16'h000f);
      for (int s = 0; s < 3; s++) begin
         {wd_host, wd_dsp, ext_rst} = 3'(4 >> s);
         @(posedge mclk);
         #1;
         {wd_host, wd_dsp, ext_rst} = 3'h0;
         wait_mon(M_FRST, 1'b0, 2);
         wait_mon(M_GRST, 1'b0, 2);
         wait_mon(M_FRST, 1'b1, FRST + 3);
         acc(1'b0, 1'b0, OFS_DSP_STATUS, 16'h0000);
         chk({12'h0, rd[3:0]}, 16'(1 << s));
         acc(1'b1, 1'b0, OFS_DSP_STATUS, 16'(1 << s));
      end
      acc(1'b1, 1'b0, OFS_DSP_RST2, 16'h0003);
      wait_mon(M_GRST, 1'b0, 3);
      wait_mon(M_GRST, 1'b1, 4);
      chk({15'h0, periph_reset_n}, 16'h0001);
      // Watchdog tick spacing, then the DSP tick gated off
      wait_mon(M_TH, 1'b1, 20);
      chk({15'h0, wd_tick_dsp}, 16'h0001);
      @(posedge mclk);
      #1;
      wait_mon(M_TH, 1'b1, 20);
      chk(16'(n), 16'(WD_DIV - 1));
      acc(1'b1, 1'b0, OFS_DSP_IDLE2, 16'h0000);
      t0 = 0;
      repeat (30) begin
         @(posedge mclk);
         #1;
         if (wd_tick_dsp !== 1'b0) t0++;
      end
      chk(16'(t0), 16'h0000);
      // DMA clock follows the transfer, one cycle late
      dma_go = 1'b1;
      @(posedge mclk);
      #1;
      dma_go = 1'b0;
      for (int i = 0; i < 10; i++) begin
         prev = dma_clk_req & dma_xfer_active;
         @(posedge mclk);
         #1;
         chk({15'h0, dma_clk_en}, {15'h0, prev});
      end
      give_verdict();
   end
endmodule
